// ==== dv/flash_event_interrupt_output_bench.sv ====
// self-checking bench for the flash event interrupt output
`timescale 1ns/1ps

module flash_event_interrupt_output_bench;
  import flash_irq_pkg::*;

  logic              clk            = 1'b0;
  logic              sys_rst        = 1'b1;
  logic [ADDR_W-1:0] reg_addr       = '0;
  logic [REG_W-1:0]  reg_wdata      = '0;
  logic              reg_wr         = 1'b0;
  logic              reg_rd         = 1'b0;
  logic [REG_W-1:0]  reg_rdata;
  logic              ready_level    = 1'b1;
  logic              ecc_single_err = 1'b0;
  logic              ecc_double_err = 1'b0;
  logic              por_cause      = 1'b1;
  logic              int_line;
  logic              int_pin_o;
  logic              int_pin_oe_n;
  logic              irq;
  int                fails          = 0;
  int                comparisons    = 0;

  always #12.5 clk = ~clk;

  flash_event_irq dut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ready_level(ready_level), .ecc_single_err(ecc_single_err),
    .ecc_double_err(ecc_double_err), .por_cause(por_cause), .int_pin_i(int_line),
    .int_pin_o(int_pin_o), .int_pin_oe_n(int_pin_oe_n), .irq(irq)
  );

  host_line_model host (.int_pin_o(int_pin_o), .int_pin_oe_n(int_pin_oe_n),
                        .int_line(int_line));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [REG_W-1:0] seen, input logic [REG_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // one event: 0 single-bit error, 1 double-bit error, 2 busy then ready
  task automatic ev(input int k);
    @(posedge clk);
    if (k == 0) ecc_single_err <= 1'b1;
    else if (k == 1) ecc_double_err <= 1'b1;
    else ready_level <= 1'b0;
    @(posedge clk);
    ecc_single_err <= 1'b0;
    ecc_double_err <= 1'b0;
    ready_level <= 1'b1;
    cyc(4);
  endtask

  // pulled pin: wire low, irq high; released: wire high, irq low
  task automatic pin(input logic low);
    chk({12'h000, int_pin_o, int_pin_oe_n, irq, int_line}, low ? 16'h0002 : 16'h0005);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset(input logic [REG_W-1:0] flags);
    rd(ENABLE_OFS, 16'hFFFF);
    rd(FLAGS_OFS, flags);
    pin(1'b0);
    rd(LINE_OFS, 16'h0006);
    wr(FLAGS_OFS, 16'h0004);
    rd(FLAGS_OFS, 16'hFFFF);
  endtask

  task automatic t_disabled();
    ev(0);
    ev(1);
    ev(2);
    rd(FLAGS_OFS, 16'hFFFF);
    pin(1'b0);
  endtask

  task automatic t_ecc();
    // zeros written to reserved enable bits must not stick
    wr(ENABLE_OFS, 16'h0000);
    rd(ENABLE_OFS, 16'h7FEC);
    ev(0);
    pin(1'b1);
    rd(FLAGS_OFS, 16'hFFFE);
    ev(1);
    rd(FLAGS_OFS, 16'hFFFC);
    wr(FLAGS_OFS, 16'h0001);
    cyc(2);
    pin(1'b1);
    rd(FLAGS_OFS, 16'hFFFD);
    wr(FLAGS_OFS, 16'h0002);
    cyc(2);
    pin(1'b0);
  endtask

  task automatic t_ready();
    ev(2);
    pin(1'b1);
    rd(FLAGS_OFS, 16'hFFEF);
    cyc(20);
    rd(FLAGS_OFS, 16'hFFEF);
    wr(ENABLE_OFS, 16'h7FFC);
    cyc(2);
    pin(1'b0);
    rd(FLAGS_OFS, 16'hFFFF);
    rd(ENABLE_OFS, 16'h7FFC);
  endtask

  task automatic t_outdis();
    wr(ENABLE_OFS, 16'h7FEC);
    ev(1);
    pin(1'b1);
    wr(ENABLE_OFS, 16'hFFEC);
    cyc(2);
    pin(1'b0);
    rd(FLAGS_OFS, 16'hFFFF);
    ev(0);
    rd(FLAGS_OFS, 16'hFFFE);
    pin(1'b0);
    wr(ENABLE_OFS, 16'h7FEC);
    cyc(2);
    pin(1'b1);
    rd(4'hC, READ_UNMAPPED);
    wr(LINE_OFS, 16'hFFFF);
    rd(LINE_OFS, 16'h0003);
    // switch off the one-bit channel while its flag still holds the pin
    wr(ENABLE_OFS, 16'h7FED);
    cyc(2);
    pin(1'b0);
    rd(FLAGS_OFS, 16'hFFFF);
    rd(ENABLE_OFS, 16'h7FED);
    ev(0);
    rd(FLAGS_OFS, 16'hFFFF);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    cyc(2);
    t_reset(16'hFFFB);
    t_disabled();
    t_ecc();
    t_ready();
    t_outdis();
    // hardware reset with the pin released: power-on flag must stay high
    @(posedge clk);
    sys_rst <= 1'b1;
    por_cause <= 1'b0;
    cyc(3);
    pin(1'b0);
    @(posedge clk);
    sys_rst <= 1'b0;
    cyc(2);
    t_reset(16'hFFFF);
    end_of_test();
  end

  // the whole run is well under a thousand cycles
  initial begin
    #100us;
    fails++;
    end_of_test();
  end
endmodule

// ==== dv/host_line_model.sv ====
// pulled-up request wire as the host controller sees it
`timescale 1ns/1ps

module host_line_model (
  // open-drain driver of the device
  input  wire logic int_pin_o,
  input  wire logic int_pin_oe_n,
  // resolved wire level
  output logic      int_line
);
  // a released wire is held high by the pull-up, never left floating
  assign int_line = int_pin_oe_n ? 1'b1 : int_pin_o;
endmodule

// ==== verilog/flash_event_irq.sv ====
// event enable and flag registers driving the open-drain request line
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps

module flash_event_irq
  import flash_irq_pkg::*;
(
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             sys_rst,
  // register port
  input  wire logic [flash_irq_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [flash_irq_pkg::REG_W-1:0]  reg_wdata,
  input  wire logic                             reg_wr,
  input  wire logic                             reg_rd,
  output logic      [flash_irq_pkg::REG_W-1:0]  reg_rdata,
  // event sources
  input  wire logic                             ready_level,
  input  wire logic                             ecc_single_err,
  input  wire logic                             ecc_double_err,
  input  wire logic                             por_cause,
  // open-drain request pin
  input  wire logic                             int_pin_i,
  output logic                                  int_pin_o,
  output logic                                  int_pin_oe_n,
  // level interrupt, high while the pin is pulled
  output logic                                  irq
);

  import flash_irq_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  // an enabled channel whose flag reads zero, with the output on
  function automatic logic pending(input logic [REG_W-1:0] fl,
                                   input logic [REG_W-1:0] en);
    pending = ~en[OUT_OFF_BIT] & (|(~fl & ~en & SOURCE_MASK));
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [REG_W-1:0] interrupt_enable_config;
  logic [REG_W-1:0] interrupt_event_flags;
  logic             drive;
  logic             por_check;

  logic             wr_enable;
  logic             wr_flags;
  logic             ready_rise;
  logic [REG_W-1:0] next_enable;
  logic [REG_W-1:0] enable_now;
  logic [REG_W-1:0] event_vec;
  logic [REG_W-1:0] set_vec;
  logic [REG_W-1:0] clr_vec;
  logic [REG_W-1:0] next_flags;

  // ****************************************
  // address decode
  // ****************************************
  assign wr_enable = reg_wr && (reg_addr == ENABLE_OFS);
  assign wr_flags  = reg_wr && (reg_addr == FLAGS_OFS);

  // ****************************************
  // busy-to-ready edge
  // ****************************************
  rise_detect #(
    .WIDTH     (1),
    .RESET_LVL (READY_RESET)
  ) u_ready_edge (
    .clk     (clk),
    .sys_rst (sys_rst),
    .level   (ready_level),
    .rise    (ready_rise)
  );

  // ****************************************
  // enable register
  // ****************************************
  // reserved positions are forced to one on every write
  assign next_enable = (reg_wdata & ENABLE_WMASK) | ENABLE_RSVD;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      interrupt_enable_config <= ENABLE_RESET;
    end else if (wr_enable) begin
      interrupt_enable_config <= next_enable;
    end
  end

  enable_write_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    wr_enable |=> interrupt_enable_config == (($past(reg_wdata) & ENABLE_WMASK) | ENABLE_RSVD)
  ) else $error("enable write did not land with reserved bits at one");

  // the enable value that governs this cycle's events, so an event
  // in the cycle of a disabling write is not recorded
  assign enable_now = wr_enable ? next_enable : interrupt_enable_config;

  // ****************************************
  // event flags
  // ****************************************
  always_comb begin
    event_vec            = '0;
    event_vec[READY_BIT] = ready_rise;
    event_vec[ECC2_BIT]  = ecc_double_err;
    event_vec[ECC1_BIT]  = ecc_single_err;
  end

  // the ready and ECC channels record only while their enable bit reads zero; the power-on flag ignores its enable bit
  always_comb begin
    set_vec          = event_vec & ~enable_now & SOURCE_MASK;
    set_vec[POR_BIT] = por_check & por_cause;
  end

  disabled_ecc2_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    interrupt_enable_config[ECC2_BIT] && interrupt_event_flags[ECC2_BIT] && !reg_wr
    |=> interrupt_event_flags[ECC2_BIT]
  ) else $error("disabled two-bit channel recorded an event");

  always_comb begin
    clr_vec = '0;
    if (wr_flags) begin
      clr_vec = reg_wdata & FLAGS_WMASK;
    end
    if (wr_enable) begin
      clr_vec = clr_vec | (reg_wdata & SOURCE_MASK);
      if (reg_wdata[OUT_OFF_BIT]) begin
        clr_vec = FLAGS_RESET;
      end
    end
  end

  // a write that turns a channel off must leave its flag clear, even
  // when that channel's event arrives in the same cycle
  chan_off_all_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    wr_enable |=> (interrupt_event_flags & $past(reg_wdata) & SOURCE_MASK)
                  == ($past(reg_wdata) & SOURCE_MASK)
  ) else $error("disabled channel kept its flag");

  por_flag_clear_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    wr_flags && reg_wdata[POR_BIT] && !por_check |=> interrupt_event_flags[POR_BIT]
  ) else $error("power-on flag not reset by writing one");

  // flags are active low: clearing forces one, an event forces zero,
  // and an event in the clearing cycle wins so that none is lost
  assign next_flags = (interrupt_event_flags | clr_vec) & ~set_vec;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      interrupt_event_flags <= FLAGS_RESET;
    end else begin
      interrupt_event_flags <= next_flags;
    end
  end

  ecc1_flag_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(interrupt_event_flags[ECC1_BIT]) |-> $past(ecc_single_err)
  ) else $error("one-bit flag set with no error");

  // the reset cause is looked at once, in the first cycle after release;
  // a pin reset leaves the power-on flag at one
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      por_check <= 1'b1;
    end else begin
      por_check <= 1'b0;
    end
  end

  por_flag_set_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(interrupt_event_flags[POR_BIT]) |-> $past(por_check) && $past(por_cause)
  ) else $error("power-on flag set outside the first cycle");

  // ****************************************
  // request pin
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      drive <= 1'b0;
    end else begin
      drive <= pending(interrupt_event_flags, interrupt_enable_config);
    end
  end

  // the pin is never driven high; the pull-up returns it
  assign int_pin_o    = 1'b0;
  assign int_pin_oe_n = ~drive;
  assign irq          = drive;

  // looked at on the second edge after release, when por_check has dropped
  line_after_reset_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(por_check) |-> int_pin_oe_n && !irq
  ) else $error("request pin not released after reset");

  pin_pull_timing_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(interrupt_event_flags[ECC1_BIT]) && !interrupt_enable_config[OUT_OFF_BIT]
    && !interrupt_enable_config[ECC1_BIT] |=> irq
  ) else $error("request pin not pulled one cycle after the flag");

  // ****************************************
  // read port
  // ****************************************
  // the host finds the cause in the flags after the pin falls
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= READ_UNMAPPED;
    end else if (reg_rd) begin
      case (reg_addr)
        ENABLE_OFS: begin
          reg_rdata <= interrupt_enable_config;
        end
        FLAGS_OFS: begin
          reg_rdata <= interrupt_event_flags;
        end
        LINE_OFS: begin
          reg_rdata <= {13'h0000, int_pin_i, ready_level, drive};
        end
        default: begin
          reg_rdata <= READ_UNMAPPED;
        end
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  pin_follows_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    pending(interrupt_event_flags, interrupt_enable_config) |=> !int_pin_oe_n && irq
  ) else $error("request pin not pulled for a pending event");

  pin_released_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !pending(interrupt_event_flags, interrupt_enable_config) |=> int_pin_oe_n && !irq
  ) else $error("request pin pulled with nothing pending");

  out_off_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    interrupt_enable_config[OUT_OFF_BIT] |=> int_pin_oe_n
  ) else $error("request pin pulled while output disabled");

  out_off_clear_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    wr_enable && reg_wdata[OUT_OFF_BIT] && (set_vec == '0)
    |=> interrupt_event_flags == FLAGS_RESET ##1 int_pin_oe_n
  ) else $error("output disable did not clear flags and pin");

  chan_off_clear_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    wr_enable && reg_wdata[ECC1_BIT]
    |=> interrupt_event_flags[ECC1_BIT] && interrupt_enable_config[ECC1_BIT]
  ) else $error("channel disable did not clear its flag");

  flag_reset_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    wr_flags && reg_wdata[ECC2_BIT] && !ecc_double_err |=> interrupt_event_flags[ECC2_BIT]
  ) else $error("writing one did not reset the flag");

  flag_holds_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !interrupt_event_flags[READY_BIT] && !clr_vec[READY_BIT]
    |=> !interrupt_event_flags[READY_BIT]
  ) else $error("occurred flag dropped without a clear");

  ready_record_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !interrupt_enable_config[READY_BIT] && !reg_wr && ready_level && !$past(ready_level)
    && !por_check |=> !interrupt_event_flags[READY_BIT]
  ) else $error("busy-to-ready edge not recorded");

  ecc2_record_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !interrupt_enable_config[ECC2_BIT] && !reg_wr && ecc_double_err
    |=> !interrupt_event_flags[ECC2_BIT] ##1 !int_pin_oe_n || interrupt_enable_config[OUT_OFF_BIT]
  ) else $error("two-bit error not recorded");

  ecc1_record_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !interrupt_enable_config[ECC1_BIT] && !reg_wr && ecc_single_err
    |=> !interrupt_event_flags[ECC1_BIT]
  ) else $error("one-bit error not recorded");

  disabled_ignored_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    interrupt_enable_config[ECC1_BIT] && interrupt_event_flags[ECC1_BIT] && !reg_wr
    |=> interrupt_event_flags[ECC1_BIT]
  ) else $error("disabled channel recorded an event");

  reset_state_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(por_check) |-> $past(interrupt_enable_config) == ENABLE_RESET && $past(int_pin_oe_n)
  ) else $error("reset did not disable all sources");

  por_flag_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    por_check |=> interrupt_event_flags[POR_BIT] == !$past(por_cause) || $past(reg_wr)
  ) else $error("power-on flag does not match the reset cause");

  reserved_one_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    ((interrupt_enable_config & ENABLE_RSVD) == ENABLE_RSVD)
    && ((interrupt_event_flags | FLAGS_WMASK) == FLAGS_RESET)
  ) else $error("reserved bit reads zero");

  open_drain_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !int_pin_o && (int_pin_oe_n != irq)
  ) else $error("request pin driven high");

  error_flags_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(interrupt_event_flags[ECC2_BIT]) |-> $past(ecc_double_err)
  ) else $error("two-bit flag set with no error");

  ready_flag_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(interrupt_event_flags[READY_BIT]) |-> $past(ready_rise)
  ) else $error("ready flag set with no transition");

endmodule

// ==== verilog/flash_irq_pkg.sv ====
// constants shared by the flash event interrupt output logic
package flash_irq_pkg;

  // ****************************************
  // register port
  // ****************************************
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned REG_W  = 16;

  localparam logic [ADDR_W-1:0] ENABLE_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] FLAGS_OFS  = 4'h4;
  localparam logic [ADDR_W-1:0] LINE_OFS   = 4'h8;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned OUT_OFF_BIT = 15;
  localparam int unsigned READY_BIT   = 4;
  localparam int unsigned POR_BIT     = 2;
  localparam int unsigned ECC2_BIT    = 1;
  localparam int unsigned ECC1_BIT    = 0;

  // ****************************************
  // masks and values after reset
  // ****************************************
  // event channels that can pull the request line
  localparam logic [REG_W-1:0] SOURCE_MASK   = 16'h0013;
  // enable bits that software can change; the rest hold one
  localparam logic [REG_W-1:0] ENABLE_WMASK  = 16'h8013;
  localparam logic [REG_W-1:0] ENABLE_RSVD   = 16'h7FEC;
  // flag bits that software can reset by writing one
  localparam logic [REG_W-1:0] FLAGS_WMASK   = 16'h0017;
  localparam logic [REG_W-1:0] ENABLE_RESET  = 16'hFFFF;
  localparam logic [REG_W-1:0] FLAGS_RESET   = 16'hFFFF;
  localparam logic [REG_W-1:0] READ_UNMAPPED = 16'h0000;

  // value seen on the ready line while reset is applied
  localparam logic READY_RESET = 1'b1;

endpackage

// ==== verilog/rise_detect.sv ====
// rising edge detector for a group of level inputs
`timescale 1ns/1ps

module rise_detect #(
  parameter int unsigned WIDTH      = 1,
  parameter logic        RESET_LVL  = 1'b1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // levels in, one-cycle pulses out
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);

  // ****************************************
  // one detector per input
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      logic prev;

      // prev resets to the idle level so that release of reset
      // alone never reads as an edge
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          prev <= RESET_LVL;
        end else begin
          prev <= level[i];
        end
      end

      assign rise[i] = level[i] & ~prev;
    end
  endgenerate

endmodule
